/* src/oau_pkg.sv */
// Notes on behaviour
// RQ1: immediate source: operand byte feeds A, F, stack pointer or X; two bytes.
// RQ2: direct source: operand addresses RAM or register space; result to A, F, stack pointer or X.
// RQ3: indexed source: operand plus index addresses the source; two-byte instruction.
// RQ4: arithmetic source modes take the destination register as second operand.
// RQ5: direct destination: result to operand address; arithmetic also reads it.
// RQ6: indexed destination: source always accumulator; arithmetic reads summed location.
// RQ7: direct destination immediate: op1 is result address, op2 immediate; three bytes.
// RQ8: indexed destination immediate: op1 plus index is result, op2 immediate; three bytes.
// RQ9: indexed destination arithmetic reads then writes back the same summed location.
// RQ10: memory-to-memory copy only in RAM, op2 location into op1; three bytes.
// RQ11: indirect source reads pointer at operand, loads pointed byte into accumulator.
// RQ12: indirect destination reads pointer at operand, stores accumulator there.
// RQ13: indirect pointer is incremented and written back after the transfer.
// RQ14: arithmetic gets exactly two sources; copies use a single source. Code holds o_alu_two low for arithmetic in M_MEM_MEM and indirect modes.
// RQ15: index register supplies the offset in every indexed mode.
// RQ16: register-space accesses use the bank chosen by flags bit 4.
// RQ17: operands follow opcode in order; index sums wrap modulo 256.
// RQ18: pointer increment wraps 255 to 0 and leaves flags untouched.
package oau_pkg;
  localparam int unsigned BANK_SELECT_BIT = 4;
  localparam logic [1:0] LEN_SHORT = 2'h2;
  localparam logic [1:0] LEN_LONG = 2'h3;
  localparam logic [7:0] PTR_STEP = 8'h01;

  typedef enum logic [3:0] {
    M_SRC_IMM = 4'h0,
    M_SRC_DIR = 4'h1,
    M_SRC_IDX = 4'h2,
    M_DST_DIR = 4'h3,
    M_DST_IDX = 4'h4,
    M_DST_DIR_IMM = 4'h5,
    M_DST_IDX_IMM = 4'h6,
    M_MEM_MEM = 4'h7,
    M_SRC_IND = 4'h8,
    M_DST_IND = 4'h9
  } oau_mode_t;

  typedef enum logic [1:0] {
    R_ACC = 2'h0,
    R_FLAGS = 2'h1,
    R_STACK = 2'h2,
    R_INDEX = 2'h3
  } oau_reg_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_RD = 4'h1,
    S_CAP = 4'h2,
    S_IRD = 4'h3,
    S_ICAP = 4'h4,
    S_OPND = 4'h5,
    S_EXEC = 4'h6,
    S_WB = 4'h7,
    S_INC = 4'h8,
    S_DONE = 4'h9
  } oau_state_t;
endpackage

/* src/oau_operand_addressing_unit.sv */
`timescale 1ns/10ps
`default_nettype none
module oau_operand_addressing_unit (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // instruction from fetch path
  input wire logic i_start,
  input wire oau_pkg::oau_mode_t i_mode,
  input wire logic i_arith,
  input wire oau_pkg::oau_reg_t i_reg_sel,
  input wire logic i_reg_space,
  input wire logic [7:0] i_operand1,
  input wire logic [7:0] i_operand2,
  // core register values
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_flags,
  input wire logic [7:0] i_stack_pointer,
  input wire logic [7:0] i_index,
  // data memory and register space
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [7:0] o_mem_addr,
  output logic o_mem_reg,
  output logic o_mem_bank,
  output logic [7:0] o_mem_wdata,
  input wire logic [7:0] i_mem_rdata,
  // arithmetic unit
  output logic o_alu_go,
  output logic o_alu_two,
  output logic [7:0] o_alu_a,
  output logic [7:0] o_alu_b,
  input wire logic [7:0] i_alu_result,
  // core register write-back and status
  output logic o_reg_wr,
  output oau_pkg::oau_reg_t o_reg_sel,
  output logic [7:0] o_reg_data,
  output logic [1:0] o_len,
  output logic o_busy,
  output logic o_done
);
  import oau_pkg::*;

  oau_state_t state_q, state_d;
  oau_mode_t mode_q;
  oau_reg_t sel_q;
  logic arith_q, space_q, bank_q;
  logic [7:0] op1_q, op2_q, acc_q, idx_q, regv_q, data_q, ptr_q;
  logic [7:0] addr_q, addr_d, wdata_q, wdata_d, alu_a_q, alu_b_q;
  logic [1:0] len_q;

  // mode classes; decoded in several places
  function automatic logic f_indexed(input oau_mode_t m);
    return m == M_SRC_IDX || m == M_DST_IDX || m == M_DST_IDX_IMM;
  endfunction
  function automatic logic f_indirect(input oau_mode_t m);
    return m == M_SRC_IND || m == M_DST_IND;
  endfunction
  function automatic logic f_src_mode(input oau_mode_t m);
    return m == M_SRC_IMM || m == M_SRC_DIR || m == M_SRC_IDX;
  endfunction
  function automatic logic f_needs_read(input oau_mode_t m, input logic ar);
    return m == M_SRC_DIR || m == M_SRC_IDX || m == M_MEM_MEM || f_indirect(m)
      || (ar && !f_src_mode(m));
  endfunction
  function automatic logic [1:0] f_len(input oau_mode_t m);
    return (m == M_DST_DIR_IMM || m == M_DST_IDX_IMM || m == M_MEM_MEM) ?
      LEN_LONG : LEN_SHORT;
  endfunction

  // effective address; the sum wraps to eight bits
  wire logic [7:0] ea = f_indexed(mode_q) ? 8'(op1_q + idx_q) : op1_q; // RQ15 RQ17
  wire logic two_src = arith_q && mode_q != M_MEM_MEM && !f_indirect(mode_q); // RQ14
  wire logic ram_only = mode_q == M_MEM_MEM || f_indirect(mode_q);
  wire logic dst_is_reg = f_src_mode(mode_q) || mode_q == M_SRC_IND;
  wire logic [7:0] rd_addr = mode_q == M_MEM_MEM ? op2_q :
    (f_indirect(mode_q) ? op1_q : ea); // RQ10 RQ11 RQ12
  wire logic [7:0] ptr_next = 8'(ptr_q + PTR_STEP); // RQ18

  // first operand source, per mode
  wire logic [7:0] src_a =
    mode_q == M_SRC_IMM ? op1_q : // RQ1
    mode_q == M_DST_DIR ? regv_q : // RQ5
    (mode_q == M_DST_IDX || mode_q == M_DST_IND) ? acc_q : // RQ6 RQ12
    (mode_q == M_DST_DIR_IMM || mode_q == M_DST_IDX_IMM) ? op2_q : // RQ7 RQ8
    data_q; // RQ2 RQ3 RQ10 RQ11
  // second operand: register for source modes, location for destination modes
  wire logic [7:0] src_b = f_src_mode(mode_q) ? regv_q : data_q; // RQ4 RQ5 RQ6 RQ9
  // copies bypass the arithmetic result
  wire logic [7:0] result = arith_q ? i_alu_result : alu_a_q;
  wire logic [7:0] dst_addr = mode_q == M_DST_IND ? ptr_q : ea; // RQ9 RQ12

  // sequencing
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    unique case (state_q)
      S_IDLE: begin
        if (i_start) begin
          state_d = S_RD;
        end
      end
      S_RD: state_d = S_CAP;
      S_CAP: state_d = mode_q == M_SRC_IND ? S_IRD : S_OPND;
      S_IRD: state_d = S_ICAP;
      S_ICAP: state_d = S_OPND;
      S_OPND: state_d = S_EXEC;
      S_EXEC: begin
        state_d = S_WB;
        addr_d = dst_addr;
        wdata_d = result;
      end
      S_WB: begin
        state_d = f_indirect(mode_q) ? S_INC : S_DONE;
        addr_d = op1_q; // RQ13
        wdata_d = ptr_next; // RQ13
      end
      S_INC: state_d = S_DONE;
      S_DONE: state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
    if (state_q == S_IDLE && i_start && !f_needs_read(i_mode, i_arith)) begin
      state_d = S_OPND;
    end
  end

  // instruction capture; registers sampled once so mid-flight changes are harmless
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_q <= M_SRC_IMM;
      sel_q <= R_ACC;
      {arith_q, space_q, bank_q} <= 3'h0;
      {op1_q, op2_q, acc_q, idx_q, regv_q} <= 40'h0;
      len_q <= LEN_SHORT;
    end else if (state_q == S_IDLE && i_start) begin
      mode_q <= i_mode;
      sel_q <= i_mode == M_SRC_IND ? R_ACC : i_reg_sel; // RQ11
      arith_q <= i_arith;
      space_q <= i_reg_space;
      bank_q <= i_flags[BANK_SELECT_BIT]; // RQ16
      op1_q <= i_operand1; // RQ17
      op2_q <= i_operand2; // RQ17
      acc_q <= i_acc;
      idx_q <= i_index;
      regv_q <= i_reg_sel == R_ACC ? i_acc : i_reg_sel == R_FLAGS ? i_flags :
        i_reg_sel == R_STACK ? i_stack_pointer : i_index;
      len_q <= f_len(i_mode); // RQ1 RQ7
    end
  end

  // datapath registers
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= S_IDLE;
      {data_q, ptr_q, addr_q, wdata_q, alu_a_q, alu_b_q} <= 48'h0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      if (state_q == S_CAP || state_q == S_ICAP) begin
        data_q <= i_mem_rdata;
      end
      if (state_q == S_CAP && f_indirect(mode_q)) begin
        ptr_q <= i_mem_rdata; // RQ11 RQ12
      end
      if (state_q == S_CAP && mode_q == M_SRC_IND) begin
        addr_q <= i_mem_rdata; // RQ11
      end
      if (state_q == S_OPND) begin
        alu_a_q <= src_a;
        alu_b_q <= src_b;
      end
    end
  end

  // read address chosen once the instruction is latched
  wire logic rd_cycle = state_q == S_RD || state_q == S_IRD;
  assign o_mem_rd = rd_cycle;
  assign o_mem_wr = (state_q == S_WB && !dst_is_reg) || state_q == S_INC;
  assign o_mem_addr = state_q == S_RD ? rd_addr : addr_q;
  assign o_mem_reg = space_q && !(ram_only); // RQ10
  assign o_mem_bank = bank_q; // RQ16
  assign o_mem_wdata = wdata_q;
  assign o_alu_go = state_q == S_EXEC && arith_q;
  assign o_alu_two = two_src; // RQ14
  assign o_alu_a = alu_a_q;
  assign o_alu_b = alu_b_q;
  assign o_reg_wr = state_q == S_WB && dst_is_reg; // RQ1 RQ2 RQ3 RQ11
  assign o_reg_sel = sel_q;
  assign o_reg_data = wdata_q;
  assign o_len = len_q;
  assign o_busy = state_q != S_IDLE;
  assign o_done = state_q == S_DONE;

  // checks
  imm_operand_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RQ1
    state_q == S_OPND && mode_q == M_SRC_IMM |=> o_alu_a == op1_q)
    else $error("immediate operand not forwarded");
  index_sum_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RQ3
    o_mem_rd && state_q == S_RD && f_indexed(mode_q) |-> o_mem_addr == 8'(op1_q + idx_q))
    else $error("indexed read address wrong");
  second_src_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RQ4
    o_alu_go && f_src_mode(mode_q) |-> o_alu_b == regv_q)
    else $error("second source is not the destination register");
  acc_source_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RQ6
    state_q == S_EXEC && mode_q == M_DST_IDX |-> o_alu_a == acc_q)
    else $error("indexed destination source not accumulator");
  rmw_same_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RQ9
    state_q == S_RD && arith_q && f_indexed(mode_q) && !f_src_mode(mode_q)
      |-> ##4 o_mem_wr && o_mem_addr == ea)
    else $error("write-back location differs from read");
  ram_copy_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RQ10
    state_q == S_RD && mode_q == M_MEM_MEM |-> !o_mem_reg && o_mem_addr == op2_q)
    else $error("memory copy source wrong");
  ptr_inc_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RQ13
    state_q == S_WB && f_indirect(mode_q) |=> o_mem_wr && o_mem_addr == op1_q
      && o_mem_wdata == 8'($past(ptr_q) + PTR_STEP))
    else $error("pointer not written back incremented");
  bank_pick_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RQ16
    $rose(o_busy) |-> o_mem_bank == $past(i_flags[BANK_SELECT_BIT]))
    else $error("bank select not taken from flags");
  two_src_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RQ14
    o_alu_go |-> o_alu_two)
    else $error("operand count wrong");
  copy_one_src_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RQ14
    o_busy && !arith_q |-> !o_alu_two)
    else $error("copy claims two sources");
  op_length_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n) // RQ7
    o_done && mode_q == M_DST_DIR_IMM |-> o_len == LEN_LONG)
    else $error("three-byte length not reported");
  c_ind_src: cover property (@(posedge i_sys_clk) state_q == S_INC && mode_q == M_SRC_IND);
  c_rmw: cover property (@(posedge i_sys_clk) o_mem_wr && arith_q && mode_q == M_DST_IDX);
  c_imm: cover property (@(posedge i_sys_clk) o_reg_wr && mode_q == M_SRC_IMM);
endmodule
`default_nettype wire

/* sim/oau_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module oau_mem_model (
  // clock
  input wire logic i_sys_clk,
  // access from the block
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic i_reg,
  input wire logic i_bank,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:1023];
  // ram and the two register banks are kept apart
  wire logic [9:0] slot = {i_reg, i_reg & i_bank, i_addr};
  initial o_rdata = 8'h00;
  // read data stands one cycle only, then inverts so stale data cannot match
  always @(posedge i_sys_clk) begin
    if (i_wr) mem[slot] <= i_wdata;
    o_rdata <= i_rd ? mem[slot] : ~o_rdata;
  end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import oau_pkg::*;
  logic clk = 0, rst_n = 0, start = 0, arith = 0, space = 0;
  oau_mode_t mode = M_SRC_IMM;
  oau_reg_t rsel = R_ACC;
  logic [7:0] op1 = 0, op2 = 0, acc = 0, flg = 0, stk = 0, idx = 0;
  logic rd, wr, mreg, bank, go, two, reg_wr, busy, done;
  logic [7:0] addr, wdata, rdata, alu_a, alu_b, reg_data, wr_data;
  logic [1:0] len;
  oau_reg_t reg_sel, wr_sel;
  int failures = 0, checks_done = 0, reg_writes = 0;
  // behaves as an adder, the only arithmetic used here
  wire logic [7:0] alu_res = 8'(alu_a + alu_b);
  oau_operand_addressing_unit oau_operand_addressing_unit_i (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_start(start), .i_mode(mode), .i_arith(arith),
    .i_reg_sel(rsel), .i_reg_space(space), .i_operand1(op1), .i_operand2(op2),
    .i_acc(acc), .i_flags(flg), .i_stack_pointer(stk), .i_index(idx),
    .o_mem_rd(rd), .o_mem_wr(wr), .o_mem_addr(addr), .o_mem_reg(mreg), .o_mem_bank(bank),
    .o_mem_wdata(wdata), .i_mem_rdata(rdata), .o_alu_go(go), .o_alu_two(two),
    .o_alu_a(alu_a), .o_alu_b(alu_b), .i_alu_result(alu_res), .o_reg_wr(reg_wr),
    .o_reg_sel(reg_sel), .o_reg_data(reg_data), .o_len(len), .o_busy(busy), .o_done(done));
  oau_mem_model oau_mem_model_i (
    .i_sys_clk(clk), .i_rd(rd), .i_wr(wr), .i_addr(addr), .i_reg(mreg), .i_bank(bank),
    .i_wdata(wdata), .o_rdata(rdata));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // catch the one-cycle register write pulse
  always @(posedge clk) begin
    if (reg_wr === 1'b1) begin
      wr_data <= reg_data;
      wr_sel <= reg_sel;
      reg_writes <= reg_writes + 1;
    end
  end
  function automatic logic [9:0] sl(input logic r, input logic b, input logic [7:0] a);
    return {r, r & b, a};
  endfunction
  task automatic close_out;
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one instruction: start pulse, then bounded wait for done
  task automatic run(input oau_mode_t m, input logic ar, input oau_reg_t r, input logic s,
                     input logic [7:0] a1, input logic [7:0] a2);
    int n;
    mode = m;
    arith = ar;
    rsel = r;
    space = s;
    op1 = a1;
    op2 = a2;
    wr_data = 8'hxx;
    reg_writes = 0;
    start = 1;
    @(negedge clk);
    start = 0;
    n = 0;
    while (done !== 1'b1 && n < 30) begin
      @(negedge clk);
      n++;
    end
    if (n == 30) begin
      failures++;
      close_out();
    end
    @(negedge clk);
  endtask
  task automatic t_src_imm;
    acc = 8'h10;
    for (int i = 0; i < 4; i++) begin
      run(M_SRC_IMM, 0, oau_reg_t'(i), 0, 8'h40 + 8'(i), 8'h00);
      chk("imm copy", wr_data, 8'h40 + 8'(i));
      chk("imm target", {6'h00, wr_sel}, 8'(i));
      chk("imm len", {6'h00, len}, 8'h02);
    end
    run(M_SRC_IMM, 1, R_ACC, 0, 8'h07, 8'h00);
    chk("imm add", wr_data, 8'h17);
    chk("two sources", {7'h00, two}, 8'h01);
    chk("idle after done", {7'h00, busy}, 8'h00);
  endtask
  task automatic t_src_dir;
    flg = 8'h10;
    idx = 8'h20;
    oau_mem_model_i.mem[sl(1, 1, 8'h08)] = 8'h05;
    oau_mem_model_i.mem[sl(1, 0, 8'h08)] = 8'h50;
    run(M_SRC_DIR, 1, R_INDEX, 1, 8'h08, 8'h00);
    chk("dir bank1", wr_data, 8'h25);
    flg = 8'h00;
    run(M_SRC_DIR, 1, R_INDEX, 1, 8'h08, 8'h00);
    chk("dir bank0", wr_data, 8'h70);
  endtask
  task automatic t_src_idx;
    idx = 8'hfe;
    oau_mem_model_i.mem[sl(0, 0, 8'h03)] = 8'h3c;
    run(M_SRC_IDX, 0, R_ACC, 0, 8'h05, 8'h00);
    chk("idx wrap", wr_data, 8'h3c);
  endtask
  task automatic t_dst;
    acc = 8'h22;
    oau_mem_model_i.mem[sl(0, 0, 8'h07)] = 8'h11;
    run(M_DST_DIR, 1, R_ACC, 0, 8'h07, 8'h00);
    chk("dst dir", oau_mem_model_i.mem[sl(0, 0, 8'h07)], 8'h33);
    idx = 8'h10;
    acc = 8'h02;
    oau_mem_model_i.mem[sl(0, 0, 8'h17)] = 8'h01;
    run(M_DST_IDX, 1, R_ACC, 0, 8'h07, 8'h00);
    chk("dst idx", oau_mem_model_i.mem[sl(0, 0, 8'h17)], 8'h03);
    chk("dst idx len", {6'h00, len}, 8'h02);
  endtask
  task automatic t_dst_imm;
    oau_mem_model_i.mem[sl(0, 0, 8'h30)] = 8'h04;
    run(M_DST_DIR_IMM, 1, R_ACC, 0, 8'h30, 8'h05);
    chk("dir imm", oau_mem_model_i.mem[sl(0, 0, 8'h30)], 8'h09);
    chk("dir imm len", {6'h00, len}, 8'h03);
    idx = 8'h08;
    run(M_DST_IDX_IMM, 0, R_ACC, 1, 8'h40, 8'h66);
    chk("idx imm", oau_mem_model_i.mem[sl(1, 0, 8'h48)], 8'h66);
    chk("idx imm len", {6'h00, len}, 8'h03);
    oau_mem_model_i.mem[sl(0, 0, 8'h50)] = 8'h10;
    run(M_DST_IDX_IMM, 1, R_ACC, 0, 8'h48, 8'h03);
    chk("idx imm add", oau_mem_model_i.mem[sl(0, 0, 8'h50)], 8'h13);
  endtask
  task automatic t_mem_mem;
    oau_mem_model_i.mem[sl(0, 0, 8'h08)] = 8'h77;
    oau_mem_model_i.mem[sl(0, 0, 8'h07)] = 8'h00;
    run(M_MEM_MEM, 0, R_ACC, 1, 8'h07, 8'h08);
    chk("mem copy", oau_mem_model_i.mem[sl(0, 0, 8'h07)], 8'h77);
    chk("mem len", {6'h00, len}, 8'h03);
    chk("copy one source", {7'h00, two}, 8'h00);
  endtask
  // reset in mid-flight: nothing is written and the length falls back to two bytes
  task automatic t_reset;
    oau_mem_model_i.mem[sl(0, 0, 8'h30)] = 8'h04;
    mode = M_DST_DIR_IMM;
    arith = 1;
    space = 0;
    op1 = 8'h30;
    op2 = 8'h05;
    start = 1;
    @(negedge clk);
    start = 0;
    @(negedge clk);
    rst_n = 0;
    #1;
    chk("reset len", {6'h00, len}, 8'h02);
    chk("reset write", {7'h00, wr}, 8'h00);
    repeat (2) @(negedge clk);
    rst_n = 1;
    run(M_DST_DIR_IMM, 1, R_ACC, 0, 8'h30, 8'h05);
    chk("rerun after reset", oau_mem_model_i.mem[sl(0, 0, 8'h30)], 8'h09);
  endtask
  task automatic t_ind;
    oau_mem_model_i.mem[sl(0, 0, 8'h08)] = 8'hff;
    oau_mem_model_i.mem[sl(0, 0, 8'hff)] = 8'h5a;
    run(M_SRC_IND, 0, R_ACC, 0, 8'h08, 8'h00);
    chk("ind load", wr_data, 8'h5a);
    chk("ptr wrap", oau_mem_model_i.mem[sl(0, 0, 8'h08)], 8'h00);
    acc = 8'ha5;
    oau_mem_model_i.mem[sl(0, 0, 8'h09)] = 8'h20;
    run(M_DST_IND, 0, R_ACC, 0, 8'h09, 8'h00);
    chk("ind store", oau_mem_model_i.mem[sl(0, 0, 8'h20)], 8'ha5);
    chk("ptr step", oau_mem_model_i.mem[sl(0, 0, 8'h09)], 8'h21);
    chk("no reg write", 8'(reg_writes), 8'h00);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    t_src_imm();
    t_src_dir();
    t_src_idx();
    t_dst();
    t_dst_imm();
    t_mem_mem();
    t_ind();
    t_reset();
    close_out();
  end
endmodule
`default_nettype wire
